// *** verilog/fslsb_pkg.sv ***
package fslsb_pkg;
  // APB register byte offsets.
  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_COMMAND  = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_FAN0_TGT = 8'h0c;
  localparam logic [7:0] REG_FAN1_TGT = 8'h10;
  localparam logic [7:0] REG_FAN0_CNT = 8'h14;
  localparam logic [7:0] REG_FAN1_CNT = 8'h18;
  localparam logic [7:0] REG_RATE     = 8'h1c;
  localparam logic [7:0] REG_TEMP0    = 8'h20;
  localparam logic [7:0] REG_TEMP1    = 8'h24;
  localparam logic [7:0] REG_TEMP2    = 8'h28;
  // Field positions.
  localparam int CFG_RUN_STOP_BIT = 6;
  localparam int CMD_ONE_SHOT_BIT = 0;
  localparam int STS_BUSY_BIT     = 7;
  localparam int STS_SAVE0_BIT    = 0;
  localparam int STS_SAVE1_BIT    = 1;
  // Reset values.
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] TARGET_RST = 8'hff;
  localparam logic [7:0] RATE_RST   = 8'h02;
  localparam logic [7:0] FAN_STOP   = 8'hff;
  // Timing.
  localparam int CLK_HZ        = 100_000_000;
  localparam int CONV_TIME_MS  = 125;
  localparam int CONV_CYCLES   = (CLK_HZ / 1000) * CONV_TIME_MS;
  localparam int CHAN_CYCLES   = CONV_CYCLES / 3;
  localparam int NUM_CHANNELS  = 3;
  localparam int PWM_STEP      = 1;
  localparam int RATE_UNIT_MS  = 1000;
  localparam int RATE_UNIT_CYC = (CLK_HZ / 1000) * RATE_UNIT_MS;
  // Converter states.
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01,
    CONV_DONE = 2'b10
  } fslsb_conv_t;
endpackage

// *** verilog/fslsb_tach.sv ***
`timescale 1ns/10ps
// Measures one fan's period in reference clock cycles and regulates its PWM duty.
module fslsb_tach #(
  parameter int CNT_W = 8
) (
  // Clock and reset.
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  // Synchronised pins.
  input  wire logic             ref_rise_i,
  input  wire logic             tach_rise_i,
  // Control and status.
  input  wire logic [CNT_W-1:0] target_i,
  output logic      [CNT_W-1:0] period_o,
  output logic      [CNT_W-1:0] duty_o,
  output logic                  save_o
);
  import fslsb_pkg::*;

  logic [CNT_W-1:0] run_cnt_ff;
  logic [CNT_W-1:0] period_ff;
  logic [CNT_W-1:0] duty_ff;
  logic             save_ff;
  logic             new_period;
  logic [CNT_W-1:0] max_cnt;

  assign max_cnt    = {CNT_W{1'b1}};
  assign new_period = tach_rise_i;

  // Counts reference periods between tach edges and saturates on a stall.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cnt_ff <= '0;
      period_ff  <= '1;
    end else if (new_period) begin
      period_ff  <= run_cnt_ff;
      run_cnt_ff <= '0;
    end else if (ref_rise_i && run_cnt_ff != max_cnt) begin
      run_cnt_ff <= run_cnt_ff + 1'b1;
    end else if (run_cnt_ff == max_cnt) begin
      period_ff  <= max_cnt;
    end
  end

  // Adjusts duty by comparing counts directly; a long period means too slow.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duty_ff <= '0;
      save_ff <= 1'b1;
    end else if (target_i == FAN_STOP[CNT_W-1:0]) begin
      duty_ff <= '0;
      save_ff <= 1'b1;
    end else begin
      save_ff <= 1'b0;
      if (new_period) begin
        if (period_ff > target_i && duty_ff != max_cnt) begin
          duty_ff <= duty_ff + CNT_W'(PWM_STEP);
        end else if (period_ff < target_i && duty_ff != '0) begin
          duty_ff <= duty_ff - CNT_W'(PWM_STEP);
        end
      end
    end
  end

  assign period_o = period_ff;
  assign duty_o   = duty_ff;
  assign save_o   = save_ff;
endmodule

// *** verilog/fslsb_conv.sv ***
`timescale 1ns/10ps
// Sequences a three-channel conversion on auto-rate or one-shot start.
module fslsb_conv #(
  parameter int CHAN_CYC = fslsb_pkg::CHAN_CYCLES,
  parameter int UNIT_CYC = fslsb_pkg::RATE_UNIT_CYC
) (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // Control.
  input  wire logic       run_stop_i,
  input  wire logic       one_shot_i,
  input  wire logic [7:0] rate_i,
  // Status.
  output logic            busy_o,
  output logic            done_o,
  output logic [1:0]      chan_o
);
  import fslsb_pkg::*;

  fslsb_conv_t state_ff;
  logic [31:0] cyc_ff;
  logic [31:0] gap_ff;
  logic [7:0]  unit_ff;
  logic [1:0]  chan_ff;
  logic        shot_ff;
  logic        auto_start;

  // Auto start only when not in standby and the idle gap has run out.
  assign auto_start = !run_stop_i && (unit_ff >= rate_i) && (gap_ff == '0);

  // Latches a one-shot request so it is not lost during a running conversion.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shot_ff <= 1'b0;
    end else if (one_shot_i) begin
      shot_ff <= 1'b1;
    end else if (state_ff == CONV_IDLE) begin
      shot_ff <= 1'b0;
    end
  end

  // Rate timer: only this runs between conversions.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_ff  <= '0;
      unit_ff <= '0;
    end else if (state_ff != CONV_IDLE) begin
      gap_ff  <= '0;
      unit_ff <= '0;
    end else if (gap_ff == 32'(UNIT_CYC - 1)) begin
      gap_ff <= '0;
      if (unit_ff != 8'hff) begin
        unit_ff <= unit_ff + 8'h01;
      end
    end else begin
      gap_ff <= gap_ff + 32'd1;
    end
  end

  // Conversion sequencer over all three channels.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= CONV_IDLE;
      cyc_ff   <= '0;
      chan_ff  <= '0;
    end else begin
      case (state_ff)
        CONV_IDLE: begin
          if (shot_ff || auto_start) begin
            state_ff <= CONV_RUN;
            cyc_ff   <= '0;
            chan_ff  <= '0;
          end
        end
        CONV_RUN: begin
          if (cyc_ff == 32'(CHAN_CYC - 1)) begin
            cyc_ff <= '0;
            if (chan_ff == 2'(NUM_CHANNELS - 1)) begin
              state_ff <= CONV_DONE;
            end else begin
              chan_ff <= chan_ff + 2'd1;
            end
          end else begin
            cyc_ff <= cyc_ff + 32'd1;
          end
        end
        CONV_DONE: begin
          state_ff <= CONV_IDLE;
        end
        default: begin
          state_ff <= CONV_IDLE;
        end
      endcase
    end
  end

  // Busy covers only the three channel slots; the done cycle just hands results over.
  assign busy_o = (state_ff == CONV_RUN);
  assign done_o = (state_ff == CONV_DONE);
  assign chan_o = chan_ff;
endmodule

// *** verilog/fslsb_top.sv ***
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Fan speed is the count of reference clock periods between two tach rising edges.
// - The PWM loop compares that period count with the target count, with no division.
// - A target of 255 stops the fan drive and puts the channel into power saving.
// - The run/stop bit set high puts the converter into standby and halts auto conversion.
// - In standby all registers are kept and bus reads and writes still work.
// - Standby affects temperature measurement only; the fan channels keep running.
// - A one-shot command in standby runs one full measurement, then standby resumes.
// - Each conversion lasts 125 ms and only the rate timer runs between conversions.
// - A busy bit shows a conversion in progress while old results stay readable.
// - Every start converts all three channels before the results are updated.
module fslsb_top #(
  parameter int CHAN_CYC = fslsb_pkg::CHAN_CYCLES,
  parameter int UNIT_CYC = fslsb_pkg::RATE_UNIT_CYC
) (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Fan pins.
  input  wire logic        fan_ref_clk_i,
  input  wire logic [1:0]  tach_pulse_input_i,
  output logic [1:0]       fan_pwm_o,
  // Converter side.
  input  wire logic [23:0] adc_sample_i,
  output logic             conv_busy_o
);
  import fslsb_pkg::*;

  logic [2:0]  ref_sync_ff;
  logic [2:0]  tach_sync0_ff;
  logic [2:0]  tach_sync1_ff;
  logic        ref_rise;
  logic [1:0]  tach_rise;
  logic [7:0]  config_ff;
  logic [7:0]  rate_ff;
  logic [7:0]  target_ff [2];
  logic [7:0]  temp_ff [3];
  logic [7:0]  shadow_ff [3];
  logic [7:0]  period [2];
  logic [7:0]  duty [2];
  logic [1:0]  save;
  logic [7:0]  pwm_cnt_ff;
  logic [1:0]  pwm_ff;
  logic        one_shot_ff;
  logic        busy;
  logic        done;
  logic [1:0]  chan;
  logic        busy_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_mux;

  // Pins from outside pass two flops; the third stage only feeds edge detection.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_sync_ff   <= '0;
      tach_sync0_ff <= '0;
      tach_sync1_ff <= '0;
    end else begin
      ref_sync_ff   <= {ref_sync_ff[1:0], fan_ref_clk_i};
      tach_sync0_ff <= {tach_sync0_ff[1:0], tach_pulse_input_i[0]};
      tach_sync1_ff <= {tach_sync1_ff[1:0], tach_pulse_input_i[1]};
    end
  end

  assign ref_rise     = ref_sync_ff[1] & ~ref_sync_ff[2];
  assign tach_rise[0] = tach_sync0_ff[1] & ~tach_sync0_ff[2];
  assign tach_rise[1] = tach_sync1_ff[1] & ~tach_sync1_ff[2];

  // One period meter and speed loop per fan, independent of standby.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fan
      fslsb_tach #(
        .CNT_W (8)
      ) u_tach (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .ref_rise_i  (ref_rise),
        .tach_rise_i (tach_rise[gi]),
        .target_i    (target_ff[gi]),
        .period_o    (period[gi]),
        .duty_o      (duty[gi]),
        .save_o      (save[gi])
      );
    end
  endgenerate

  // Free-running PWM ramp shared by both channels.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_cnt_ff <= '0;
      pwm_ff     <= '0;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      pwm_ff[0]  <= !save[0] && (pwm_cnt_ff < duty[0]);
      pwm_ff[1]  <= !save[1] && (pwm_cnt_ff < duty[1]);
    end
  end

  // Conversion sequencer; standby blocks only its auto starts.
  fslsb_conv #(
    .CHAN_CYC (CHAN_CYC),
    .UNIT_CYC (UNIT_CYC)
  ) u_conv (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .run_stop_i (config_ff[CFG_RUN_STOP_BIT]),
    .one_shot_i (one_shot_ff),
    .rate_i     (rate_ff),
    .busy_o     (busy),
    .done_o     (done),
    .chan_o     (chan)
  );

  // Each channel's sample is held in a shadow until all three are done.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shadow_ff[0] <= '0;
      shadow_ff[1] <= '0;
      shadow_ff[2] <= '0;
      temp_ff[0]   <= '0;
      temp_ff[1]   <= '0;
      temp_ff[2]   <= '0;
    end else if (done) begin
      temp_ff[0] <= shadow_ff[0];
      temp_ff[1] <= shadow_ff[1];
      temp_ff[2] <= shadow_ff[2];
    end else if (busy) begin
      shadow_ff[chan] <= adc_sample_i[8*chan +: 8];
    end
  end

  // APB decode; answer on the edge after the first access cycle, with one wait state.
  assign wr_en   = psel_i && penable_i && pwrite_i && !pready_ff;
  assign rd_en   = psel_i && penable_i && !pwrite_i && !pready_ff;
  assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= REG_TEMP2);

  // Control register writes; these survive standby untouched.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      config_ff    <= CONFIG_RST;
      rate_ff      <= RATE_RST;
      target_ff[0] <= TARGET_RST;
      target_ff[1] <= TARGET_RST;
    end else if (wr_en) begin
      case (paddr_i)
        REG_CONFIG:   config_ff    <= pwdata_i[7:0];
        REG_RATE:     rate_ff      <= pwdata_i[7:0];
        REG_FAN0_TGT: target_ff[0] <= pwdata_i[7:0];
        REG_FAN1_TGT: target_ff[1] <= pwdata_i[7:0];
        default:      config_ff    <= config_ff;
      endcase
    end
  end

  // One-shot command is a single-cycle pulse on a write of its bit.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      one_shot_ff <= 1'b0;
    end else begin
      one_shot_ff <= wr_en && (paddr_i == REG_COMMAND) && pwdata_i[CMD_ONE_SHOT_BIT];
    end
  end

  // Read data multiplexer.
  always_comb begin
    rd_mux = '0;
    case (paddr_i)
      REG_CONFIG:   rd_mux[7:0] = config_ff;
      REG_STATUS: begin
        rd_mux[STS_BUSY_BIT]  = busy;
        rd_mux[STS_SAVE0_BIT] = save[0];
        rd_mux[STS_SAVE1_BIT] = save[1];
      end
      REG_FAN0_TGT: rd_mux[7:0] = target_ff[0];
      REG_FAN1_TGT: rd_mux[7:0] = target_ff[1];
      REG_FAN0_CNT: rd_mux[7:0] = period[0];
      REG_FAN1_CNT: rd_mux[7:0] = period[1];
      REG_RATE:     rd_mux[7:0] = rate_ff;
      REG_TEMP0:    rd_mux[7:0] = temp_ff[0];
      REG_TEMP1:    rd_mux[7:0] = temp_ff[1];
      REG_TEMP2:    rd_mux[7:0] = temp_ff[2];
      default:      rd_mux      = '0;
    endcase
  end

  // APB answer registers; reads always work, standby or not.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel_i && penable_i && !pready_ff;
      pslverr_ff <= psel_i && penable_i && !pready_ff && !addr_ok;
      if (rd_en) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Registered busy pin.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= busy;
    end
  end

  assign prdata_o    = prdata_ff;
  assign pready_o    = pready_ff;
  assign pslverr_o   = pslverr_ff;
  assign fan_pwm_o   = pwm_ff;
  assign conv_busy_o = busy_ff;
endmodule

// *** verification/fslsb_top_asserts.sv ***
`timescale 1ns/10ps
// Watches the APB answers and the converter busy span at the top ports.
module fslsb_top_asserts #(
  parameter int CHAN_CYC = 10
) (
  // Clock and reset.
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  // APB slave.
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Fan and converter pins.
  input wire logic        fan_ref_clk_i,
  input wire logic [1:0]  tach_pulse_input_i,
  input wire logic [1:0]  fan_pwm_o,
  input wire logic [23:0] adc_sample_i,
  input wire logic        conv_busy_o
);
  localparam int BUSY_CYC = 3 * CHAN_CYC;
  logic [31:0] busy_len_ff;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Counts consecutive busy cycles so a whole conversion can be measured.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) busy_len_ff <= 32'h0;
    else busy_len_ff <= conv_busy_o ? busy_len_ff + 32'h1 : 32'h0;
  end
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_bad_addr;
    paddr_i > 8'h28 || paddr_i[1:0] != 2'h0;
  endsequence
  a_answer_next: assert property (s_access |=> pready_o)
    else $error("APB access not answered on the next edge");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without an access");
  a_refuse_bad: assert property (s_access ##0 s_bad_addr |=> pslverr_o)
    else $error("bad address not refused");
  a_accept_good: assert property (s_access ##0 !s_bad_addr |=> !pslverr_o)
    else $error("mapped address refused");
  a_err_read_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  a_busy_max: assert property (busy_len_ff <= BUSY_CYC)
    else $error("conversion busy too long");
  a_busy_full: assert property (!conv_busy_o && busy_len_ff != 0 |-> busy_len_ff == BUSY_CYC)
    else $error("conversion ended early");
endmodule
bind fslsb_top fslsb_top_asserts #(.CHAN_CYC(CHAN_CYC)) fslsb_top_asserts_i (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .fan_ref_clk_i(fan_ref_clk_i),
  .tach_pulse_input_i(tach_pulse_input_i), .fan_pwm_o(fan_pwm_o),
  .adc_sample_i(adc_sample_i), .conv_busy_o(conv_busy_o));

// *** verification/fslsb_fan_model.sv ***
`timescale 1ns/10ps
// Two fans with tach outputs and a free-running reference clock source.
module fslsb_fan_model #(
  parameter int REF_HALF  = 50,
  parameter int TACH_REFS = 42
) (
  input  wire logic [1:0] spin_i,
  output logic            ref_clk_o,
  output logic      [1:0] tach_o
);
  int ref_cnt = 0;
  // The reference clock runs free, out of phase with the system clock.
  initial begin
    ref_clk_o = 1'b0;
    tach_o = 2'b11;
    #3;
    forever #(REF_HALF) ref_clk_o = ~ref_clk_o;
  end
  // One tach pulse per TACH_REFS reference periods; a stalled fan rests at its pull-up.
  always @(posedge ref_clk_o) begin
    ref_cnt = (ref_cnt + 1) % TACH_REFS;
    tach_o <= (spin_i & {2{ref_cnt < TACH_REFS / 2}}) | ~spin_i;
  end
endmodule

// *** verification/test_fslsb_top.sv ***
`timescale 1ns/10ps
// Drives the block over APB beside two modelled fans and checks its answers.
module test_fslsb_top;
  import fslsb_pkg::*;
  localparam int CHAN_CYC = 10;
  typedef struct packed {
    logic        err;
    logic [31:0] msk;
    logic [31:0] exp;
  } fslsb_note_t;
  logic        clk_sys_i, rst_b_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, fan_ref_clk_i, conv_busy_o, busy_q;
  logic [7:0]  paddr_i, tgt1;
  logic [31:0] pwdata_i, prdata_o;
  logic [1:0]  tach, fan_pwm_o, spin;
  logic [23:0] adc_sample_i, old_smp, new_smp;
  fslsb_note_t notes[$];
  fslsb_note_t note;
  int          n_mismatch, n_compared, n_rise, n_busy, seed, h0, h1, b0, b1;
  fslsb_top #(.CHAN_CYC(CHAN_CYC), .UNIT_CYC(20)) fslsb_top_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .fan_ref_clk_i(fan_ref_clk_i),
    .tach_pulse_input_i(tach), .fan_pwm_o(fan_pwm_o), .adc_sample_i(adc_sample_i),
    .conv_busy_o(conv_busy_o));
  fslsb_fan_model fslsb_fan_model_i (.spin_i(spin), .ref_clk_o(fan_ref_clk_i), .tach_o(tach));
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; the expected answer is noted before the request goes out.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic [31:0] m, input logic err);
    int n;
    notes.push_back('{err, m, e});
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    n = 0;
    while (pready_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 50) n_mismatch++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  // Counts high cycles of each PWM output over one PWM period.
  task pwm_high;
    h0 = 0;
    h1 = 0;
    repeat (256) begin
      @(posedge clk_sys_i);
      h0 += fan_pwm_o[0];
      h1 += fan_pwm_o[1];
    end
  endtask
  // Takes the oldest note whenever an APB answer stands.
  always @(negedge clk_sys_i) begin
    if (pready_o === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check("prdata", {1'b0, prdata_o & note.msk}, {1'b0, note.exp & note.msk});
      check("pslverr", {32'h0, pslverr_o}, {32'h0, note.err});
    end
  end
  // Counts busy rises and busy cycles away from the driving edge.
  always @(negedge clk_sys_i) begin
    n_busy += (conv_busy_o === 1'b1);
    n_rise += (conv_busy_o === 1'b1 && busy_q !== 1'b1);
    busy_q = conv_busy_o;
  end
  // System clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Cuts a hang short.
  initial begin
    #300_000;
    n_mismatch++;
    print_verdict;
  end
  // Main sequence.
  initial begin
    seed = 26;
    rst_b_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    spin = 2'b11;
    old_smp = 24'($random(seed));
    adc_sample_i = old_smp;
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    // Reset values, power saving and refused addresses.
    rd(REG_CONFIG, 32'h0, 32'hffffffff);
    rd(REG_FAN0_TGT, 32'hff, 32'hffffffff);
    rd(REG_RATE, 32'h2, 32'hffffffff);
    rd(REG_STATUS, 32'h3, 32'h3);
    apb(1'b0, 8'h2c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 8'h05, 32'hff, 32'h0, 32'h0, 1'b1);
    check("pwm_idle", {31'h0, fan_pwm_o}, 33'h0);
    // Fan 0 aims faster than it spins and fan 1 slower, so only fan 0 gains duty.
    tgt1 = 8'hc0 | 8'($random(seed) & 32'h3e);
    wr(REG_FAN0_TGT, 32'h10);
    wr(REG_FAN1_TGT, {24'h0, tgt1});
    repeat (10000) @(posedge clk_sys_i);
    pwm_high;
    check("duty_up", 33'(h0 > 0), 33'h1);
    check("duty_floor", 33'(h1), 33'h0);
    rd(REG_FAN0_CNT, 32'h28, 32'hfc);
    rd(REG_STATUS, 32'h0, 32'h3);
    rd(REG_TEMP0, {24'h0, old_smp[7:0]}, 32'hff);
    // Standby halts conversions but the fans keep running.
    wr(REG_CONFIG, 32'h40);
    repeat (40) @(posedge clk_sys_i);
    b0 = n_rise;
    pwm_high;
    check("standby_rise", 33'(n_rise - b0), 33'h0);
    check("standby_duty", 33'(h0 > 0), 33'h1);
    rd(REG_CONFIG, 32'h40, 32'hffffffff);
    rd(REG_FAN1_TGT, {24'h0, tgt1}, 32'hffffffff);
    // A one-shot in standby converts the new sample once; old results stay readable.
    new_smp = 24'($random(seed));
    adc_sample_i <= new_smp;
    b0 = n_rise;
    b1 = n_busy;
    wr(REG_COMMAND, 32'h1);
    rd(REG_STATUS, 32'h80, 32'h80);
    rd(REG_TEMP2, {24'h0, old_smp[23:16]}, 32'hff);
    repeat (300) @(posedge clk_sys_i);
    check("shot_rise", 33'(n_rise - b0), 33'h1);
    check("shot_span", 33'(n_busy - b1), 33'(3 * CHAN_CYC));
    rd(REG_TEMP0, {24'h0, new_smp[7:0]}, 32'hff);
    rd(REG_TEMP1, {24'h0, new_smp[15:8]}, 32'hff);
    rd(REG_TEMP2, {24'h0, new_smp[23:16]}, 32'hff);
    // Back in run mode conversions recur at the programmed gap.
    wr(REG_CONFIG, 32'h0);
    b0 = n_rise;
    repeat (300) @(posedge clk_sys_i);
    check("auto_rise", 33'(n_rise - b0 >= 3), 33'h1);
    // A stalled fan reads as the longest period; target 255 parks fan 0.
    spin <= 2'b01;
    wr(REG_FAN0_TGT, 32'hff);
    repeat (4000) @(posedge clk_sys_i);
    rd(REG_FAN1_CNT, 32'hff, 32'hff);
    rd(REG_STATUS, 32'h1, 32'h1);
    pwm_high;
    check("park_duty", 33'(h0), 33'h0);
    print_verdict;
  end
endmodule
